/* dv/addon_mailbox_interrupt_service_bench.sv */
`timescale 1ns/1ps
module addon_mailbox_interrupt_service_bench;
  import amis_pkg::*;
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } amis_row_t;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, er;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, host_rd_data, rd;
  logic [3:0]     pstrb;
  amis_host_req_t host_req;
  int             errors, comparisons;
  amis_row_t      rows [12];
  always #20 pclk = ~pclk;
  amis_top i_amis_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .host_req(host_req), .host_rd_data(host_rd_data),
    .irq_n(irq_n));
  amis_far_host i_amis_far_host (.pclk(pclk), .host_req(host_req));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one idle cycle after each transfer keeps psel from being driven twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    finish_test();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    errors = 0;
    comparisons = 0;
    rows = '{'{0, 8'h20, 0, 32'hFFFF_0000, 0}, '{0, 8'h24, 0, 0, 0}, '{1, 8'h20, 0, 0, 1},
      '{1, 8'h00, 0, 0, 1}, '{0, 8'h30, 0, 0, 1}, '{1, 8'h24, 32'h1A13, 0, 0},
      '{0, 8'h24, 0, 32'h1A13, 0}, '{1, 8'h18, 32'h1122_3344, 0, 0},
      '{0, 8'h20, 0, 32'hF0FF_0000, 0}, '{0, 8'h18, 0, 32'h1122_3344, 0},
      '{1, 8'h28, 32'h1, 0, 0}, '{0, 8'h20, 0, 32'hFFFF_0000, 0}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk(32'(er), 32'(rows[i].e));
      if (!rows[i].w && !rows[i].e) chk(rd, rows[i].x);
    end
    $display("table test done");
    i_amis_far_host.pulse(1, 0, 0, 2'h0, 4'h8, 32'hAB00_0000, 3);
    @(posedge pclk);
    chk(32'(irq_n), 32'h0);
    apb(0, 8'h24, 0, rd, er);
    chk(rd, 32'h0001_1A13);
    apb(0, 8'h20, 0, rd, er);
    chk(rd, 32'hFFFF_0008);
    apb(1, 8'h24, 32'h0001_1A13, rd, er);
    apb(0, 8'h24, 0, rd, er);
    chk(rd, 32'h0001_1A13);
    apb(0, 8'h00, 0, rd, er);
    chk(rd, 32'hAB00_0000);
    apb(0, 8'h20, 0, rd, er);
    chk(rd, 32'hFFFF_0000);
    apb(1, 8'h24, 32'h0001_1A13, rd, er);
    chk(32'(irq_n), 32'h1);
    $display("incoming test done");
    i_amis_far_host.pulse(0, 1, 0, 2'h2, 4'h4, 32'h0, 0);
    @(posedge pclk);
    chk(host_rd_data, 32'h1122_3344);
    chk(32'(irq_n), 32'h0);
    apb(0, 8'h24, 0, rd, er);
    chk(rd, 32'h0002_1A13);
    apb(0, 8'h20, 0, rd, er);
    chk(rd, 32'hFFFF_0000);
    apb(1, 8'h24, 32'h0002_1A13, rd, er);
    chk(32'(irq_n), 32'h1);
    $display("outgoing test done");
    i_amis_far_host.pulse(1, 0, 0, 2'h1, 4'hF, 32'h5A5A_5A5A, 0);
    apb(0, 8'h20, 0, rd, er);
    chk(rd, 32'hFFFF_00F0);
    i_amis_far_host.pulse(0, 0, 1, 2'h0, 4'h0, 32'h0, 1);
    apb(0, 8'h20, 0, rd, er);
    chk(rd, 32'hFFFF_0000);
    $display("flag reset test done");
    // mid-run reset with an incoming request pending
    i_amis_far_host.pulse(1, 0, 0, 2'h0, 4'h8, 32'h0000_0000, 0);
    @(posedge pclk);
    chk(32'(irq_n), 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(irq_n), 32'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h24, 0, rd, er);
    chk(rd, 32'h0);
    apb(0, 8'h20, 0, rd, er);
    chk(rd, 32'hFFFF_0000);
    $display("reset test done");
    // single-byte write, then far read of that byte with interrupts off
    pstrb <= 4'h2;
    apb(1, 8'h1C, 32'h0000_BE00, rd, er);
    pstrb <= 4'hF;
    apb(0, 8'h20, 0, rd, er);
    chk(rd, 32'hDFFF_0000);
    i_amis_far_host.pulse(0, 1, 0, 2'h3, 4'h2, 32'h0, 0);
    @(posedge pclk);
    chk(host_rd_data, 32'h0000_BE00);
    chk(32'(irq_n), 32'h1);
    apb(0, 8'h20, 0, rd, er);
    chk(rd, 32'hFFFF_0000);
    $display("strobe test done");
    finish_test();
  end
endmodule

/* dv/amis_chk_assertions.sv */
`timescale 1ns/1ps
module amis_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic [31:0]              pwdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic [31:0]              prdata,
  input wire amis_pkg::amis_host_req_t host_req,
  input wire logic                     irq_n
);
  import amis_pkg::*;
  logic [31:0] cfg_ff;
  logic        acc;
  assign acc = psel && penable;
  // shadow of enables and selects, so the request line can be predicted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_ff <= 32'h0;
    else if (acc && pready && pwrite && paddr == ADDR_W'(8'h24)) cfg_ff <= pwdata;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_ro; psel && !penable && pwrite && paddr == ADDR_W'(8'h20) |=> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("flag write not refused");
  property p_unmap; psel && !penable && paddr == ADDR_W'(8'h30) |=> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_in; host_req.wr && !acc && cfg_ff[4] && host_req.mbox == cfg_ff[3:2]
    && host_req.be[cfg_ff[1:0]] |=> !irq_n; endproperty
  a_in: assert property (p_in) else $error("incoming request missing");
  property p_out; host_req.rd && !acc && cfg_ff[12] && host_req.mbox == cfg_ff[11:10]
    && host_req.be[cfg_ff[9:8]] |=> !irq_n; endproperty
  a_out: assert property (p_out) else $error("outgoing request missing");
  property p_off; !cfg_ff[12] && !cfg_ff[4] && !acc |=> irq_n; endproperty
  a_off: assert property (p_off) else $error("request with both disabled");
  property p_hold; !$past(psel && !penable) |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without setup");
  c_irq: cover property (!irq_n);
  c_rd: cover property (host_req.rd);
  c_err: cover property (pslverr);
endmodule
bind amis_top amis_chk #(.ADDR_W(ADDR_W)) i_amis_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .host_req(host_req), .irq_n(irq_n));

/* dv/amis_far_host.sv */
`timescale 1ns/1ps
module amis_far_host (
  input wire logic           pclk,
  output amis_pkg::amis_host_req_t host_req
);
  import amis_pkg::*;
  initial host_req = '0;
  // data inverted once idle so a stale word never passes for a live one
  task automatic pulse(input logic w, r, f, input logic [1:0] mb, input logic [3:0] b,
                       input logic [31:0] d, input int dly);
    repeat (dly) @(posedge pclk);
    host_req <= '{w, r, f, mb, b, d};
    @(posedge pclk);
    host_req <= '{1'b0, 1'b0, 1'b0, mb, b, ~d};
  endtask
endmodule

/* src/amis_defines.svh */
`ifndef AMIS_DEFINES_SVH
`define AMIS_DEFINES_SVH

// register byte addresses
`define AMIS_ADDR_IN_MB0   8'h00
`define AMIS_ADDR_IN_MB3   8'h0C
`define AMIS_ADDR_OUT_MB0  8'h10
`define AMIS_ADDR_OUT_MB3  8'h1C
`define AMIS_ADDR_FLAGS    8'h20
`define AMIS_ADDR_INT_CS   8'h24
`define AMIS_ADDR_GEN_CS   8'h28

// interrupt control and status fields
`define AMIS_ICS_IN_IND    16
`define AMIS_ICS_OUT_IND   17
`define AMIS_ICS_OUT_EN    12
`define AMIS_ICS_OUT_SEL_H 11
`define AMIS_ICS_OUT_SEL_L 8
`define AMIS_ICS_IN_EN     4
`define AMIS_ICS_IN_SEL_H  3
`define AMIS_ICS_IN_SEL_L  0

// flag register fields
`define AMIS_FLG_EMPTY_H   31
`define AMIS_FLG_EMPTY_L   16
`define AMIS_FLG_FULL_H    15
`define AMIS_FLG_FULL_L    0

// general control: write one resets all mailbox flags
`define AMIS_GCS_FLAG_RST  0

// reset values
`define AMIS_RST_WORD      32'h0000_0000
`define AMIS_RST_FLAGS     16'h0000
`define AMIS_RST_SEL       4'h0
`endif

/* src/amis_pkg.sv */
package amis_pkg;

  // one request from the host-side port of the bridge
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        flag_rst;
    logic [1:0]  mbox;
    logic [3:0]  be;
    logic [31:0] data;
  } amis_host_req_t;

  typedef struct packed {
    logic [3:0][31:0] in_mb;
    logic [3:0][31:0] out_mb;
    logic [15:0]      in_full;
    logic [15:0]      out_full;
    logic             in_en;
    logic [3:0]       in_sel;
    logic             out_en;
    logic [3:0]       out_sel;
    logic             in_ind;
    logic             out_ind;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq_n;
    logic [31:0]      host_rd_data;
  } amis_state_t;

endpackage

/* src/amis_top.sv */
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "amis_defines.svh"

module amis_top #(
  parameter int ADDR_W   = 8,
  parameter int MBOX_CNT = 4
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  input  wire amis_pkg::amis_host_req_t host_req,
  output logic [31:0]                   host_rd_data,
  output logic                          irq_n
);
  import amis_pkg::*;

  // byte selects and flag indices assume four mailboxes of four bytes
  if (MBOX_CNT != 4) begin : g_chk_cnt
    $error("amis_top: MBOX_CNT must be 4");
  end
  if (ADDR_W < 8) begin : g_chk_addr
    $error("amis_top: ADDR_W too small for register map");
  end

  amis_state_t s_ff;
  amis_state_t nxt_s;

  // flag index of a byte: mailbox number then byte lane
  function automatic logic [3:0] fn_flag_idx(input logic [1:0] mbox,
                                             input logic [1:0] lane);
    fn_flag_idx = {mbox, lane};
  endfunction

  function automatic logic [7:0] fn_byte_addr(input logic [ADDR_W-1:0] a);
    fn_byte_addr = {a[7:2], 2'b00};
  endfunction

  function automatic logic [31:0] fn_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    fn_merge = r;
  endfunction

  // one flag per byte: the mailbox number picks the nibble, the lane the bit
  function automatic logic [15:0] fn_mask(input logic [1:0] mbox,
                                          input logic [3:0] be);
    logic [15:0] m;
    m = 16'h0000;
    m[fn_flag_idx(mbox, 2'd0) +: 4] = be;
    fn_mask = m;
  endfunction

  // does a byte-enabled access touch the selected {mailbox, lane}
  function automatic logic fn_hit(input logic [1:0] mbox,
                                  input logic [3:0] be,
                                  input logic [3:0] sel);
    fn_hit = (mbox == sel[3:2]) && be[sel[1:0]];
  endfunction

  logic [7:0]  addr_b;
  logic        hi_zero;
  logic        setup;
  logic        access;
  logic        sel_in_mb;
  logic        sel_out_mb;
  logic        sel_flags;
  logic        sel_ics;
  logic        sel_gcs;
  logic        refuse;
  logic [1:0]  mb_idx;
  logic [31:0] ics_rd;
  logic [31:0] flags_rd;
  logic [31:0] rd_word;
  logic [3:0]  in_bit;
  logic [3:0]  out_bit;
  logic        loc_rd_in;
  logic        loc_wr_out;
  logic        loc_wr_ics;
  logic        flag_rst_any;
  logic        w1c_in;
  logic        w1c_out;
  logic        in_hit;
  logic        out_hit;
  logic [15:0] in_clr;
  logic [15:0] in_set;
  logic [15:0] out_clr;
  logic [15:0] out_set;

  always_comb begin
    addr_b     = fn_byte_addr(paddr);
    hi_zero    = (ADDR_W <= 8) ? 1'b1 : (paddr >> 8) == '0;
    setup      = psel & ~penable;
    access     = psel & penable & s_ff.pready;
    sel_in_mb  = hi_zero && addr_b >= `AMIS_ADDR_IN_MB0 && addr_b <= `AMIS_ADDR_IN_MB3;
    sel_out_mb = hi_zero && addr_b >= `AMIS_ADDR_OUT_MB0 && addr_b <= `AMIS_ADDR_OUT_MB3;
    sel_flags  = hi_zero && addr_b == `AMIS_ADDR_FLAGS;
    sel_ics    = hi_zero && addr_b == `AMIS_ADDR_INT_CS;
    sel_gcs    = hi_zero && addr_b == `AMIS_ADDR_GEN_CS;
    // incoming mailboxes and flags are read-only from this side
    refuse     = !(sel_in_mb || sel_out_mb || sel_flags || sel_ics || sel_gcs)
                 || (pwrite && (sel_in_mb || sel_flags));
    mb_idx     = addr_b[3:2];
    in_bit     = s_ff.in_sel;
    out_bit    = s_ff.out_sel;
  end

  // access-phase and far-side strobes; a refused write matches none of them
  always_comb begin
    loc_rd_in    = access && !pwrite && sel_in_mb;
    loc_wr_out   = access && pwrite && sel_out_mb;
    loc_wr_ics   = access && pwrite && sel_ics;
    flag_rst_any = (access && pwrite && sel_gcs && pwdata[`AMIS_GCS_FLAG_RST])
                   || host_req.flag_rst;
    w1c_out      = loc_wr_ics && pwdata[`AMIS_ICS_OUT_IND];
    w1c_in       = loc_wr_ics && pwdata[`AMIS_ICS_IN_IND] && !s_ff.in_full[in_bit];
    in_hit       = host_req.wr && s_ff.in_en && fn_hit(host_req.mbox, host_req.be, in_bit);
    out_hit      = host_req.rd && s_ff.out_en && fn_hit(host_req.mbox, host_req.be, out_bit);
  end

  // clears and sets kept apart, so that a set in the same cycle wins
  always_comb begin
    in_clr  = 16'h0000;
    out_clr = 16'h0000;
    if (flag_rst_any) begin
      in_clr  = '1;
      out_clr = '1;
    end
    if (loc_rd_in) begin
      in_clr = in_clr | fn_mask(mb_idx, 4'hF);
    end
    // far-side read empties its bytes
    if (host_req.rd) begin
      out_clr = out_clr | fn_mask(host_req.mbox, host_req.be);
    end
    in_set  = host_req.wr ? fn_mask(host_req.mbox, host_req.be) : 16'h0000;
    out_set = loc_wr_out ? fn_mask(mb_idx, pstrb) : 16'h0000;
  end

  always_comb begin
    ics_rd = `AMIS_RST_WORD;
    ics_rd[`AMIS_ICS_IN_IND] = s_ff.in_ind;
    ics_rd[`AMIS_ICS_OUT_IND] = s_ff.out_ind;
    ics_rd[`AMIS_ICS_OUT_EN] = s_ff.out_en;
    ics_rd[`AMIS_ICS_OUT_SEL_H:`AMIS_ICS_OUT_SEL_L] = s_ff.out_sel;
    ics_rd[`AMIS_ICS_IN_EN] = s_ff.in_en;
    ics_rd[`AMIS_ICS_IN_SEL_H:`AMIS_ICS_IN_SEL_L] = s_ff.in_sel;
  end

  always_comb begin
    flags_rd = `AMIS_RST_WORD;
    flags_rd[`AMIS_FLG_EMPTY_H:`AMIS_FLG_EMPTY_L] = ~s_ff.out_full;
    flags_rd[`AMIS_FLG_FULL_H:`AMIS_FLG_FULL_L] = s_ff.in_full;
  end

  always_comb begin
    rd_word = `AMIS_RST_WORD;
    if (sel_in_mb) begin
      rd_word = s_ff.in_mb[mb_idx];
    end else if (sel_out_mb) begin
      rd_word = s_ff.out_mb[mb_idx];
    end else if (sel_flags) begin
      rd_word = flags_rd;
    end else if (sel_ics) begin
      rd_word = ics_rd;
    end
  end

  always_comb begin
    nxt_s = s_ff;

    // answer in the cycle after setup: one access cycle, no extra wait
    nxt_s.pready  = setup;
    nxt_s.pslverr = setup & refuse;
    // read data is taken at setup and stands until the next setup
    if (setup) begin
      nxt_s.prdata = rd_word;
    end

    nxt_s.in_full  = (s_ff.in_full & ~in_clr) | in_set;
    nxt_s.out_full = (s_ff.out_full & ~out_clr) | out_set;

    if (loc_wr_out) begin
      nxt_s.out_mb[mb_idx] = fn_merge(s_ff.out_mb[mb_idx], pwdata, pstrb);
    end

    // far side fills an incoming mailbox
    if (host_req.wr) begin
      nxt_s.in_mb[host_req.mbox] = fn_merge(s_ff.in_mb[host_req.mbox],
                                            host_req.data, host_req.be);
    end

    // far side drains an outgoing mailbox
    if (host_req.rd) begin
      nxt_s.host_rd_data = s_ff.out_mb[host_req.mbox];
    end

    if (loc_wr_ics) begin
      nxt_s.out_en  = pwdata[`AMIS_ICS_OUT_EN];
      nxt_s.out_sel = pwdata[`AMIS_ICS_OUT_SEL_H:`AMIS_ICS_OUT_SEL_L];
      nxt_s.in_en   = pwdata[`AMIS_ICS_IN_EN];
      nxt_s.in_sel  = pwdata[`AMIS_ICS_IN_SEL_H:`AMIS_ICS_IN_SEL_L];
    end

    // write one clears out_ind, and in_ind only once its selected incoming byte is empty; a new event wins
    nxt_s.in_ind  = (s_ff.in_ind & ~w1c_in) | in_hit;
    nxt_s.out_ind = (s_ff.out_ind & ~w1c_out) | out_hit;

    nxt_s.irq_n = ~((nxt_s.in_ind & nxt_s.in_en) | (nxt_s.out_ind & nxt_s.out_en));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff          <= '0;
      s_ff.irq_n    <= 1'b1;
      s_ff.in_sel   <= `AMIS_RST_SEL;
      s_ff.out_sel  <= `AMIS_RST_SEL;
      s_ff.in_full  <= `AMIS_RST_FLAGS;
      s_ff.out_full <= `AMIS_RST_FLAGS;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pready       = s_ff.pready;
  assign pslverr      = s_ff.pslverr;
  assign prdata       = s_ff.prdata;
  assign host_rd_data = s_ff.host_rd_data;
  assign irq_n        = s_ff.irq_n;

endmodule
